// ---- rtl/ctab_bank.sv ----
// Purpose: Trim register bank for a two-core sampling converter.
// Assumes: Mode and input-select signals come from logic on ref_clk.
// Notes:   Trim outputs are registered; a select change shows one cycle later.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module ctab_bank
(
    input  wire logic                          ref_clk,         // 50 MHz clock
    input  wire logic                          nrst,            // Async reset, low active
    input  wire logic [ctab_pkg::ADDR_W-1:0]   reg_addr,        // Register address
    input  wire logic [ctab_pkg::DATA_W-1:0]   reg_wdata,       // Write data
    input  wire logic                          reg_wr,          // Write strobe
    input  wire logic                          reg_rd,          // Read strobe
    output logic      [ctab_pkg::DATA_W-1:0]   reg_rdata,       // Read data, cycle after read
    input  wire logic [ctab_pkg::TIM_W-1:0]    fuse_tim_a,      // Fused core A timing default
    input  wire logic [ctab_pkg::TIM_W-1:0]    fuse_tim_b,      // Fused core B timing default
    input  wire logic [ctab_pkg::OFF_W-1:0]    fuse_off_a_df,   // Fused dual first default
    input  wire logic [ctab_pkg::OFF_W-1:0]    fuse_off_a_ds,   // Fused dual second default
    input  wire logic [ctab_pkg::OFF_W-1:0]    fuse_off_a_sf,   // Fused single first default
    input  wire logic                          dual_mode,       // 1 dual, 0 single channel
    input  wire logic                          fg_cal_en,       // Foreground calibration on
    input  wire logic                          core_a_second,   // Core A samples second input
    input  wire logic                          core_b_second,   // Core B samples second input
    output logic      [ctab_pkg::TIM_W-1:0]    core_a_tim_trim, // Core A sampling delay trim
    output logic                               core_a_tim_vld,  // Core A timing trim applies
    output logic      [ctab_pkg::TIM_W-1:0]    core_b_tim_trim, // Core B sampling delay trim
    output logic                               core_b_tim_vld,  // Core B timing trim applies
    output logic      [ctab_pkg::OFF_W-1:0]    core_a_off_trim, // Core A offset trim
    output logic                               core_a_off_vld,  // Core A offset trim applies
    output logic                               fuse_done        // Fuse defaults loaded
);
    import ctab_pkg::*;

    ctab_fuse_state_t          fuse_state_reg;
    ctab_fuse_state_t          fuse_state_next;
    logic                      fuse_load;
    logic [TIM_W-1:0]          tim_a_q;
    logic [TIM_W-1:0]          tim_b_q;
    logic [OFF_W-1:0]          off_df_q;
    logic [OFF_W-1:0]          off_ds_q;
    logic [OFF_W-1:0]          off_sf_q;
    logic                      hit_tim_a;
    logic                      hit_tim_b;
    logic                      hit_off_df;
    logic                      hit_off_ds;
    logic                      hit_off_sf;
    logic [DATA_W-1:0]         rdata_reg;
    logic [DATA_W-1:0]         rdata_next;
    logic                      sel_tim_a;
    logic                      sel_tim_b;
    logic                      sel_off_df;
    logic                      sel_off_ds;
    logic                      sel_off_sf;
    logic [TIM_W-1:0]          a_tim_reg;
    logic [TIM_W-1:0]          a_tim_next;
    logic                      a_tim_vld_reg;
    logic [TIM_W-1:0]          b_tim_reg;
    logic [TIM_W-1:0]          b_tim_next;
    logic                      b_tim_vld_reg;
    logic [OFF_W-1:0]          a_off_reg;
    logic [OFF_W-1:0]          a_off_next;
    logic                      a_off_vld_reg;

    // Fuse copy runs once, on the second edge after reset release; a strap
    // cannot be taken under async reset, so it waits for the clock
    always_comb
    begin
        fuse_state_next = fuse_state_reg;
        fuse_load       = 1'b0;
        case (fuse_state_reg)
            CTAB_FUSE_WAIT: fuse_state_next = CTAB_FUSE_LOAD;
            CTAB_FUSE_LOAD:
            begin
                fuse_load       = 1'b1;        // R6
                fuse_state_next = CTAB_FUSE_DONE;
            end
            CTAB_FUSE_DONE: fuse_state_next = CTAB_FUSE_DONE;
            default:        fuse_state_next = CTAB_FUSE_WAIT;
        endcase
    end

    // Fuse loader state
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fuse_state_reg <= CTAB_FUSE_WAIT;
        end
        else
        begin
            fuse_state_reg <= fuse_state_next;
        end
    end

    assign fuse_done = (fuse_state_reg == CTAB_FUSE_DONE);

    // Write decode
    assign hit_tim_a  = reg_wr && (reg_addr == OFS_TIM_A_SINGLE_SECOND); // R1
    assign hit_tim_b  = reg_wr && (reg_addr == OFS_TIM_B_SINGLE_SECOND); // R2
    assign hit_off_df = reg_wr && (reg_addr == OFS_OFF_A_DUAL_FIRST);    // R3
    assign hit_off_ds = reg_wr && (reg_addr == OFS_OFF_A_DUAL_SECOND);   // R4
    assign hit_off_sf = reg_wr && (reg_addr == OFS_OFF_A_SINGLE_FIRST);  // R5

    // Trim storage, one instance per register
    ctab_trim_reg #(.W(TIM_W)) u_tim_a
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .fuse_load (fuse_load),
        .fuse_val  (fuse_tim_a),
        .wr_hit    (hit_tim_a),
        .wr_val    (reg_wdata[TIM_W-1:0]),
        .q         (tim_a_q)
    );

    ctab_trim_reg #(.W(TIM_W)) u_tim_b
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .fuse_load (fuse_load),
        .fuse_val  (fuse_tim_b),
        .wr_hit    (hit_tim_b),
        .wr_val    (reg_wdata[TIM_W-1:0]),
        .q         (tim_b_q)
    );

    ctab_trim_reg #(.W(OFF_W)) u_off_df
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .fuse_load (fuse_load),
        .fuse_val  (fuse_off_a_df),
        .wr_hit    (hit_off_df),
        .wr_val    (reg_wdata[OFF_W-1:0]),
        .q         (off_df_q)
    );

    ctab_trim_reg #(.W(OFF_W)) u_off_ds
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .fuse_load (fuse_load),
        .fuse_val  (fuse_off_a_ds),
        .wr_hit    (hit_off_ds),
        .wr_val    (reg_wdata[OFF_W-1:0]),
        .q         (off_ds_q)
    );

    ctab_trim_reg #(.W(OFF_W)) u_off_sf
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .fuse_load (fuse_load),
        .fuse_val  (fuse_off_a_sf),
        .wr_hit    (hit_off_sf),
        .wr_val    (reg_wdata[OFF_W-1:0]),
        .q         (off_sf_q)
    );

    // Read decode; reserved and unmapped bits read zero, data only
    // in the cycle after the strobe so a stale value is never seen
    always_comb
    begin
        rdata_next = RST_RD;
        if (reg_rd)
        begin
            if (reg_addr == OFS_TIM_A_SINGLE_SECOND)
            begin
                rdata_next = {8'h00, tim_a_q};            // R8
            end
            else if (reg_addr == OFS_TIM_B_SINGLE_SECOND)
            begin
                rdata_next = {8'h00, tim_b_q};            // R8
            end
            else if (reg_addr == OFS_OFF_A_DUAL_FIRST)
            begin
                rdata_next = {4'h0, off_df_q};
            end
            else if (reg_addr == OFS_OFF_A_DUAL_SECOND)
            begin
                rdata_next = {4'h0, off_ds_q};
            end
            else if (reg_addr == OFS_OFF_A_SINGLE_FIRST)
            begin
                rdata_next = {4'h0, off_sf_q};
            end
        end
    end

    // Mode selects for each trim
    assign sel_tim_a  = !dual_mode && core_a_second && fg_cal_en;  // R1
    assign sel_tim_b  = !dual_mode && core_b_second && fg_cal_en;  // R2
    assign sel_off_df = dual_mode && !core_a_second && fg_cal_en;  // R3
    assign sel_off_ds = dual_mode && core_a_second && fg_cal_en;   // R4
    assign sel_off_sf = !dual_mode && !core_a_second;              // R5

    // Apply path: unselected trims give zero and a low valid
    always_comb
    begin
        a_tim_next = RST_TIM;
        b_tim_next = RST_TIM;
        a_off_next = RST_OFF;
        if (sel_tim_a)
        begin
            a_tim_next = tim_a_q;                          // R7
        end
        if (sel_tim_b)
        begin
            b_tim_next = tim_b_q;                          // R7
        end
        if (sel_off_df)
        begin
            a_off_next = off_df_q;                         // R3
        end
        else if (sel_off_ds)
        begin
            a_off_next = off_ds_q;                         // R4
        end
        else if (sel_off_sf)
        begin
            a_off_next = off_sf_q;                         // R5
        end
    end

    // Registered outputs to the converter cores
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_reg     <= RST_RD;
            a_tim_reg     <= RST_TIM;
            a_tim_vld_reg <= 1'b0;
            b_tim_reg     <= RST_TIM;
            b_tim_vld_reg <= 1'b0;
            a_off_reg     <= RST_OFF;
            a_off_vld_reg <= 1'b0;
        end
        else
        begin
            rdata_reg     <= rdata_next;
            a_tim_reg     <= a_tim_next;
            a_tim_vld_reg <= sel_tim_a;                    // R9
            b_tim_reg     <= b_tim_next;
            b_tim_vld_reg <= sel_tim_b;                    // R9
            a_off_reg     <= a_off_next;
            a_off_vld_reg <= sel_off_df || sel_off_ds || sel_off_sf;
        end
    end

    assign reg_rdata       = rdata_reg;
    assign core_a_tim_trim = a_tim_reg;
    assign core_a_tim_vld  = a_tim_vld_reg;
    assign core_b_tim_trim = b_tim_reg;
    assign core_b_tim_vld  = b_tim_vld_reg;
    assign core_a_off_trim = a_off_reg;
    assign core_a_off_vld  = a_off_vld_reg;

    // Checks on the apply path and register access
    sequence wr_tim_a_s;
        reg_wr && (reg_addr == OFS_TIM_A_SINGLE_SECOND);
    endsequence

    sequence rd_tim_a_s;
        reg_rd && (reg_addr == OFS_TIM_A_SINGLE_SECOND);
    endsequence

    tim_a_apply_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
        sel_tim_a |=> core_a_tim_vld && (core_a_tim_trim == $past(tim_a_q)))
        else $error("core A timing trim not applied");

    tim_b_apply_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
        sel_tim_b |=> core_b_tim_vld && (core_b_tim_trim == $past(tim_b_q)))
        else $error("core B timing trim not applied");

    off_dual_first_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
        (dual_mode && !core_a_second && fg_cal_en)
        |=> core_a_off_vld && (core_a_off_trim == $past(off_df_q)))
        else $error("dual first offset trim not applied");

    off_dual_second_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
        (dual_mode && core_a_second && fg_cal_en)
        |=> core_a_off_vld && (core_a_off_trim == $past(off_ds_q)))
        else $error("dual second offset trim not applied");

    off_single_first_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
        (!dual_mode && !core_a_second)
        |=> core_a_off_vld && (core_a_off_trim == $past(off_sf_q)))
        else $error("single first offset trim not applied");

    fuse_default_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R6
        (fuse_load && !reg_wr) |=> (tim_a_q == $past(fuse_tim_a))
        && (off_sf_q == $past(fuse_off_a_sf)) && fuse_done)
        else $error("fuse default not loaded");

    tim_mode_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R7
        core_a_tim_vld |-> !$past(dual_mode) && $past(core_a_second) && $past(fg_cal_en))
        else $error("timing trim valid outside its mode");

    write_readback_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
        (wr_tim_a_s ##1 (rd_tim_a_s and !reg_wr))
        |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00FF))
        else $error("written timing trim not read back");

    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
        (!sel_tim_b && !hit_tim_b && !fuse_load)
        |=> !core_b_tim_vld && (core_b_tim_trim == RST_TIM) && $stable(tim_b_q))
        else $error("idle timing trim leaked or changed");

    read_only_once_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == RST_RD)
        else $error("read data outside the read cycle");
endmodule // ctab_bank

// ---- rtl/ctab_pkg.sv ----
// Purpose: Constants shared by the core trim adjust bank.
// Assumes: Plain register port with 16-bit address and 16-bit data.
// Notes:   Offsets are byte addresses on the plain port, as printed.
//
// Summary of operation
// [R1] Core A single-channel second-input timing trim, 8 bits, read/write, applied when selected.
// [R2] Core B single-channel second-input timing trim, 8 bits, read/write, applied when selected.
// [R3] Core A dual-channel first-input offset trim, 12 bits, applied with calibration on.
// [R4] Core A dual-channel second-input offset trim, 12 bits, applied with calibration on.
// [R5] Core A single-channel first-input offset trim, 12 bits, applied in single mode.
// [R6] After reset every trim register loads its default from fuse storage.
// [R7] Timing trims shift the sampling instant; core and mode pick the active one.
// [R8] Software reads and overwrites trims; written value replaces the fused default.
// [R9] Inactive trims keep their value and do not reach the converter.
package ctab_pkg;
    // Register bus and trim field widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int TIM_W  = 8;
    localparam int OFF_W  = 12;

    // Register offsets
    localparam logic [15:0] OFS_TIM_A_SINGLE_SECOND = 16'h031A;
    localparam logic [15:0] OFS_TIM_B_SINGLE_SECOND = 16'h031B;
    localparam logic [15:0] OFS_OFF_A_DUAL_FIRST    = 16'h0344;
    localparam logic [15:0] OFS_OFF_A_DUAL_SECOND   = 16'h0346;
    localparam logic [15:0] OFS_OFF_A_SINGLE_FIRST  = 16'h0348;

    // Values held before the fuse load
    localparam logic [7:0]  RST_TIM = 8'h00;
    localparam logic [11:0] RST_OFF = 12'h000;
    localparam logic [15:0] RST_RD  = 16'h0000;

    // Fuse loader states
    typedef enum logic [1:0]
    {
        CTAB_FUSE_WAIT = 2'b00,
        CTAB_FUSE_LOAD = 2'b01,
        CTAB_FUSE_DONE = 2'b10
    } ctab_fuse_state_t;
endpackage

// ---- rtl/ctab_trim_reg.sv ----
// Purpose: One trim register with fuse default and software overwrite.
// Assumes: Fuse value is static and on the same clock.
// Notes:   A software write in the load cycle wins over the fuse value.
`timescale 1ns/1ps
module ctab_trim_reg
#(
    parameter int W = 8
)
(
    input  wire logic         ref_clk,   // System clock
    input  wire logic         nrst,      // Async reset, low active
    input  wire logic         fuse_load, // One-cycle fuse copy pulse
    input  wire logic [W-1:0] fuse_val,  // Factory default
    input  wire logic         wr_hit,    // Software write to this register
    input  wire logic [W-1:0] wr_val,    // Software write value
    output logic      [W-1:0] q          // Stored trim
);
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // Write beats fuse so software never loses its value
    always_comb
    begin
        q_next = q_reg;
        if (wr_hit)
        begin
            q_next = wr_val;                   // R8
        end
        else if (fuse_load)
        begin
            q_next = fuse_val;                 // R6
        end
    end

    // Held value, changed only by a software write or the fuse load
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q_reg <= '0;
        end
        else
        begin
            q_reg <= q_next;                   // R9
        end
    end

    assign q = q_reg;
endmodule // ctab_trim_reg

// ---- sim/ctab_bank_test.sv ----
// Purpose: Self-checking bench for the trim register bank.
// Assumes: Fuse inputs static; register port never stalls the master.
// Notes:   Random trims from a fixed seed, with all-ones and zero corners.
`timescale 1ns/1ps
module ctab_bank_test;
    import ctab_pkg::*;

    logic        ref_clk;
    logic        nrst;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [7:0]  fuse_tim_a;
    logic [7:0]  fuse_tim_b;
    logic [11:0] fuse_off_a_df;
    logic [11:0] fuse_off_a_ds;
    logic [11:0] fuse_off_a_sf;
    logic        dual_mode;
    logic        fg_cal_en;
    logic        core_a_second;
    logic        core_b_second;
    logic [7:0]  core_a_tim_trim;
    logic        core_a_tim_vld;
    logic [7:0]  core_b_tim_trim;
    logic        core_b_tim_vld;
    logic [11:0] core_a_off_trim;
    logic        core_a_off_vld;
    logic        fuse_done;
    int          fails;
    int          n_tests;
    logic [15:0] reg_mem [5];  // Expected stored values
    logic [15:0] addr_tab [5];
    logic [15:0] mask_tab [5]; // Only the trim field is stored

    ctab_bank ctab_bank_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fuse_tim_a(fuse_tim_a), .fuse_tim_b(fuse_tim_b), .fuse_off_a_df(fuse_off_a_df),
        .fuse_off_a_ds(fuse_off_a_ds), .fuse_off_a_sf(fuse_off_a_sf),
        .dual_mode(dual_mode), .fg_cal_en(fg_cal_en), .core_a_second(core_a_second),
        .core_b_second(core_b_second), .core_a_tim_trim(core_a_tim_trim),
        .core_a_tim_vld(core_a_tim_vld), .core_b_tim_trim(core_b_tim_trim),
        .core_b_tim_vld(core_b_tim_vld), .core_a_off_trim(core_a_off_trim),
        .core_a_off_vld(core_a_off_vld), .fuse_done(fuse_done));

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Strobe stays up on return so writes and a read can follow with no gap
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
    endtask

    // Read data stand one cycle only, then fall back to zero
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        reg_wr   <= 1'b0;
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check("reg_rdata", {16'h0000, reg_rdata}, {16'h0000, e});
        @(posedge ref_clk);
        #1;
        check("rdata_idle", {16'h0000, reg_rdata}, 32'h00000000);
    endtask

    task automatic wr_exp(input int i, input logic [15:0] d);
        wr(addr_tab[i], d);
        reg_mem[i] = d & mask_tab[i];
    endtask

    // Packed view: a_vld, a_tim, b_vld, b_tim, off_vld, off
    function automatic logic [31:0] exp_apply(input logic [3:0] s);
        logic        d;
        logic        fg;
        logic        as;
        logic        bs;
        logic [31:0] r;
        {d, fg, as, bs} = s;
        r = 32'h00000000;
        if (!d && as && fg)
            r[30:22] = {1'b1, reg_mem[0][7:0]};
        if (!d && bs && fg)
            r[21:13] = {1'b1, reg_mem[1][7:0]};
        if (d && !as && fg)
            r[12:0] = {1'b1, reg_mem[2][11:0]};
        else if (d && as && fg)
            r[12:0] = {1'b1, reg_mem[3][11:0]};
        else if (!d && !as)
            r[12:0] = {1'b1, reg_mem[4][11:0]};
        return r;
    endfunction

    task automatic apply_chk(input logic [3:0] s);
        @(posedge ref_clk);
        {dual_mode, fg_cal_en, core_a_second, core_b_second} <= s;
        @(posedge ref_clk);
        #1;
        check("trim_out", {1'b0, core_a_tim_vld, core_a_tim_trim, core_b_tim_vld,
            core_b_tim_trim, core_a_off_vld, core_a_off_trim}, exp_apply(s));
    endtask

    // Watchdog sized well above the few hundred cycles the tests need
    initial
    begin
        #(20 * 5000);
        fails++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h1B81));
        ref_clk = 1'b0;
        nrst = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {dual_mode, fg_cal_en, core_a_second, core_b_second} = 4'h0;
        fails = 0;
        n_tests = 0;
        addr_tab = '{OFS_TIM_A_SINGLE_SECOND, OFS_TIM_B_SINGLE_SECOND, OFS_OFF_A_DUAL_FIRST,
            OFS_OFF_A_DUAL_SECOND, OFS_OFF_A_SINGLE_FIRST};
        mask_tab = '{16'h00FF, 16'h00FF, 16'h0FFF, 16'h0FFF, 16'h0FFF};
        fuse_tim_a = 8'($urandom);
        fuse_tim_b = 8'($urandom);
        fuse_off_a_df = 12'($urandom);
        fuse_off_a_ds = 12'($urandom);
        fuse_off_a_sf = 12'($urandom);
        reg_mem = '{{8'h00, fuse_tim_a}, {8'h00, fuse_tim_b}, {4'h0, fuse_off_a_df},
            {4'h0, fuse_off_a_ds}, {4'h0, fuse_off_a_sf}};
        repeat (4) @(posedge ref_clk);
        #1;
        check("reset_out", {reg_rdata, 15'h0000, fuse_done}, 32'h00000000);
        @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #1;
        check("fuse_done", {31'h0, fuse_done}, 32'h00000000);
        @(posedge ref_clk);
        #1;
        check("fuse_done", {31'h0, fuse_done}, 32'h00000001);
        // Fused defaults are readable
        for (int i = 0; i < 5; i++)
            rd_chk(addr_tab[i], reg_mem[i]);
        for (int k = 0; k < 16; k++)
            apply_chk(4'(k));
        // Rewrite with corners then random data, read straight back
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                wr_exp(i, (r == 0) ? 16'hFFFF : (r == 1) ? 16'h0000 : 16'($urandom));
                rd_chk(addr_tab[i], reg_mem[i]);
            end
            for (int k = 0; k < 16; k++)
                apply_chk(4'(k));
        end
        // Unmapped places read zero and ignore writes
        wr(16'h031C, 16'($urandom));
        wr(16'h0347, 16'($urandom));
        rd_chk(16'h031C, 16'h0000);
        rd_chk(16'h0319, 16'h0000);
        for (int i = 0; i < 5; i++)
            rd_chk(addr_tab[i], reg_mem[i]);
        end_sim();
    end
endmodule // ctab_bank_test
